// *** core/fbrf_pkg.sv ***
`default_nettype none
package fbrf_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // storage geometry
  localparam int unsigned FBRF_WORD_W = 32;
  localparam int unsigned FBRF_BANK_ENTRIES = 16;
  localparam int unsigned FBRF_NUM_BANKS = 2;
  localparam int unsigned FBRF_PORT_WORDS = 4;   // widest port view
  localparam int unsigned FBRF_PORT_W = 128;     // four words
  localparam int unsigned FBRF_MTX_W = 512;      // sixteen words

  ////////////////////////////////////////////////////////////////////////////
  // fpu_status_control word: only the three mapping/size bits are held
  localparam int FSC_SWAP_POS = 21;   // bank_swap_bit
  localparam int FSC_PAIR_POS = 20;   // transfer_pair_bit
  localparam int FSC_DBL_POS = 19;    // double_mode_bit
  localparam logic [31:0] FSC_RESET = 32'h0000_0000;
  localparam logic [31:0] FSC_WMASK = 32'h0038_0000;

  ////////////////////////////////////////////////////////////////////////////
  // words covered by each view
  localparam logic [4:0] CNT_SINGLE = 5'h01;
  localparam logic [4:0] CNT_PAIR = 5'h02;
  localparam logic [4:0] CNT_VECTOR = 5'h04;
  localparam logic [4:0] CNT_MATRIX = 5'h10;

  // register views that an access may name
  typedef enum logic [5:0] {
    VW_SINGLE     = 6'b00_0001,  // single_view_reg
    VW_DOUBLE     = 6'b00_0010,  // double_view_reg
    VW_VECTOR     = 6'b00_0100,  // vector_view_reg
    VW_EXT_SINGLE = 6'b00_1000,  // extended_single_reg
    VW_EXT_DOUBLE = 6'b01_0000,  // extended_double_reg
    VW_MATRIX     = 6'b10_0000   // extended_matrix
  } fbrf_view_type;

  typedef struct packed {
    logic valid;
    logic is_move;             // fp_move_instr access
    fbrf_view_type view;
    logic [3:0] idx;
  } fbrf_rd_req_type;

  typedef struct packed {
    logic valid;
    logic is_move;
    fbrf_view_type view;
    logic [3:0] idx;
    logic [FBRF_PORT_W-1:0] data;  // left-justified, word n on top
  } fbrf_wr_req_type;

  typedef struct packed {
    logic ok;
    logic bank;
    logic [3:0] base;
    logic [4:0] cnt;
  } fbrf_map_type;

endpackage
`default_nettype wire

// *** core/fbrf_view_map.sv ***
`default_nettype none
module fbrf_view_map (
  input wire logic swap,
  input wire logic pair_mode,
  input wire logic dbl_mode,
  input wire logic is_move,
  input wire fbrf_pkg::fbrf_view_type view,
  input wire logic [3:0] idx,
  output fbrf_pkg::fbrf_map_type map
);
  import fbrf_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // resolve a view name to bank, first entry and word count
  always_comb begin
    map = '0;
    case (view)
      VW_SINGLE: begin
        map.ok = 1'b1;
        map.bank = swap;                                     // see RULE2
        if ((is_move && pair_mode) || (!is_move && dbl_mode)) begin
          map.base = {idx[3:1], 1'b0};                       // see RULE8
          map.cnt = CNT_PAIR;                                // see RULE9
        end else begin
          map.base = idx;
          map.cnt = CNT_SINGLE;
        end
      end
      VW_DOUBLE: begin
        map.ok = 1'b1;
        map.bank = swap;
        map.base = {idx[3:1], 1'b0};                         // see RULE4
        map.cnt = CNT_PAIR;
      end
      VW_VECTOR: begin
        map.ok = 1'b1;
        map.bank = swap;
        map.base = {idx[3:2], 2'b00};                        // see RULE5
        map.cnt = CNT_VECTOR;
      end
      VW_EXT_SINGLE: begin
        map.ok = 1'b1;
        map.bank = ~swap;                                    // see RULE3
        if (is_move && pair_mode) begin
          map.base = {idx[3:1], 1'b0};                       // see RULE8
          map.cnt = CNT_PAIR;
        end else begin
          map.base = idx;
          map.cnt = CNT_SINGLE;
        end
      end
      VW_EXT_DOUBLE: begin
        map.ok = 1'b1;
        map.bank = ~swap;
        map.base = {idx[3:1], 1'b0};                         // see RULE6
        map.cnt = CNT_PAIR;
      end
      VW_MATRIX: begin
        map.ok = 1'b1;
        map.bank = ~swap;                                    // see RULE7
        map.base = 4'h0;
        map.cnt = CNT_MATRIX;
      end
      default: begin
        map = '0;   // not a one-hot view: refused
      end
    endcase
  end

endmodule // fbrf_view_map
`default_nettype wire

// *** core/fbrf_regfile.sv ***
// Functional notes
// RULE1: storage is thirty-two 32-bit words in two banks of sixteen.
// RULE2: single view names 0..15 sit on bank 0 when swap is 0, else bank 1.
// RULE3: extended single names always sit on the bank opposite the primary.
// RULE4: double view n is primary words n and n+1, n even, in that order.
// RULE5: vector view n is primary words n..n+3 for n of 0, 4, 8 or 12.
// RULE6: extended double n is extended words n and n+1, n even.
// RULE7: the extended matrix view is all sixteen extended words at once.
// RULE8: with the pair bit set, a move on a single name moves a 64-bit pair.
// RULE9: with the double bit set, operand accesses use the paired views; here extended single names stay single.
// RULE10: after the swap bit changes no access uses the old mapping.
`default_nettype none
module fbrf_regfile (
  input wire logic clk,
  input wire logic rstn,
  input wire logic fsc_we,
  input wire logic [31:0] fsc_wdata,
  output logic [31:0] fsc_rdata,
  input wire fbrf_pkg::fbrf_rd_req_type rd_req,
  output logic rd_valid,
  output logic rd_err,
  output logic [fbrf_pkg::FBRF_PORT_W-1:0] rd_data,
  output logic [fbrf_pkg::FBRF_MTX_W-1:0] mtx_data,
  input wire fbrf_pkg::fbrf_wr_req_type wr_req,
  output logic wr_done,
  output logic wr_err
);
  import fbrf_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // status/control word: only swap, pair and double bits are kept
  logic [31:0] fsc_r;
  logic [31:0] fsc_nxt;
  logic swap_now;
  logic pair_now;
  logic dbl_now;

  // reserved bits are masked so they always read back as zero
  always_comb begin
    fsc_nxt = fsc_r;
    if (fsc_we) begin
      fsc_nxt = fsc_wdata & FSC_WMASK;
    end
  end

  // mode word register, cleared by reset
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      fsc_r <= FSC_RESET;
    end else begin
      fsc_r <= fsc_nxt;
    end
  end

  // accesses in the writing cycle already see the new bits, so the
  // decoder needs no bubble after a mode change
  assign swap_now = fsc_nxt[FSC_SWAP_POS];   // see RULE10
  assign pair_now = fsc_nxt[FSC_PAIR_POS];
  assign dbl_now = fsc_nxt[FSC_DBL_POS];
  assign fsc_rdata = fsc_r;

  ////////////////////////////////////////////////////////////////////////////
  // view decoding for both ports
  fbrf_map_type rmap;
  fbrf_map_type wmap;

  // read-side decode; the write side has its own copy so that a read and
  // a write on different views resolve in the same cycle
  fbrf_view_map u_rd_map (
    .swap(swap_now),
    .pair_mode(pair_now),
    .dbl_mode(dbl_now),
    .is_move(rd_req.is_move),
    .view(rd_req.view),
    .idx(rd_req.idx),
    .map(rmap)
  );

  // write-side decode, steered by the same live mode bits as the read
  // side so the two ports never disagree on the mapping
  fbrf_view_map u_wr_map (
    .swap(swap_now),
    .pair_mode(pair_now),
    .dbl_mode(dbl_now),
    .is_move(wr_req.is_move),
    .view(wr_req.view),
    .idx(wr_req.idx),
    .map(wmap)
  );

  ////////////////////////////////////////////////////////////////////////////
  // physical storage, one flop word per bank entry
  logic [FBRF_WORD_W-1:0] phys [FBRF_NUM_BANKS][FBRF_BANK_ENTRIES];
  logic wr_ok;

  // the matrix view is read-only here; a 512-bit write port was not worth
  // the wiring, so such writes are refused
  assign wr_ok = wr_req.valid && wmap.ok && (wmap.cnt <= CNT_VECTOR);

  // one word per entry, each with its own write select; no enable is
  // needed, an unselected word simply reloads itself
  for (genvar gb = 0; gb < FBRF_NUM_BANKS; gb++) begin : g_bank
    for (genvar ge = 0; ge < FBRF_BANK_ENTRIES; ge++) begin : g_ent
      logic [FBRF_WORD_W-1:0] ent_r;
      logic [FBRF_WORD_W-1:0] ent_nxt;
      logic [3:0] off;

      // entry takes word (ge - base) of the left-justified write data
      always_comb begin
        off = 4'(ge) - wmap.base;
        ent_nxt = ent_r;
        if (wr_ok && (wmap.bank == 1'(gb)) && (4'(ge) >= wmap.base)
            && ({1'b0, off} < wmap.cnt)) begin
          ent_nxt = wr_req.data[(2'd3 - off[1:0]) * 32 +: 32]; // see RULE1
        end
      end

      // entry register, zero after reset
      always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          ent_r <= '0;
        end else begin
          ent_r <= ent_nxt;
        end
      end

      // flat copy for the read muxes
      assign phys[gb][ge] = ent_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read port: one cycle from request to registered data
  logic rd_valid_r;
  logic rd_valid_nxt;
  logic rd_err_r;
  logic rd_err_nxt;
  logic [FBRF_PORT_W-1:0] rd_data_r;
  logic [FBRF_PORT_W-1:0] rd_data_nxt;
  logic [FBRF_MTX_W-1:0] mtx_r;
  logic [FBRF_MTX_W-1:0] mtx_nxt;
  wire logic [FBRF_MTX_W-1:0] mtx_view;

  // extended bank laid out with word 0 on top; the bank index comes from
  // the live decode, so a swap in the same cycle already picks the bank
  for (genvar gm = 0; gm < FBRF_BANK_ENTRIES; gm++) begin : g_mtx
    assign mtx_view[(15 - gm) * 32 +: 32] = phys[rmap.bank][gm]; // see RULE7
  end

  // a read racing a write to the same word returns the old value
  always_comb begin
    rd_valid_nxt = rd_req.valid && rmap.ok;
    rd_err_nxt = rd_req.valid && !rmap.ok;
    rd_data_nxt = rd_data_r;
    mtx_nxt = mtx_r;
    if (rd_valid_nxt) begin
      if (rmap.cnt == CNT_MATRIX) begin
        mtx_nxt = mtx_view;   // see RULE7
      end else begin
        rd_data_nxt = '0;   // unused lower words read as zero
        for (int k = 0; k < FBRF_PORT_WORDS; k++) begin
          if (5'(k) < rmap.cnt) begin
            // word n on top keeps pair order n, n+1
            rd_data_nxt[(3 - k) * 32 +: 32] =
              phys[rmap.bank][rmap.base + 4'(k)];            // see RULE4
          end
        end
      end
    end
  end

  // answers land one edge after the request; the data words are not
  // cleared between reads, so a user must qualify them with rd_valid
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rd_valid_r <= 1'b0;
      rd_err_r <= 1'b0;
      rd_data_r <= '0;
      mtx_r <= '0;
    end else begin
      rd_valid_r <= rd_valid_nxt;
      rd_err_r <= rd_err_nxt;
      rd_data_r <= rd_data_nxt;
      mtx_r <= mtx_nxt;
    end
  end

  // read outputs straight from their flops
  assign rd_valid = rd_valid_r;
  assign rd_err = rd_err_r;
  assign rd_data = rd_data_r;
  assign mtx_data = mtx_r;

  ////////////////////////////////////////////////////////////////////////////
  // write acknowledge: one-cycle pulses, registered
  logic wr_done_r;
  logic wr_done_nxt;
  logic wr_err_r;
  logic wr_err_nxt;

  // a refused write still answers, so the issuer never waits on a
  // request that stored nothing
  always_comb begin
    wr_done_nxt = wr_ok;
    wr_err_nxt = wr_req.valid && !wr_ok;
  end

  // acknowledge flops
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wr_done_r <= 1'b0;
      wr_err_r <= 1'b0;
    end else begin
      wr_done_r <= wr_done_nxt;
      wr_err_r <= wr_err_nxt;
    end
  end

  // write outputs straight from their flops
  assign wr_done = wr_done_r;
  assign wr_err = wr_err_r;

endmodule // fbrf_regfile
`default_nettype wire

// *** verif/fbrf_regfile_chk.sv ***
`default_nettype none
module fbrf_regfile_chk (
  input wire logic clk,
  input wire logic rstn,
  input wire logic fsc_we,
  input wire logic [31:0] fsc_wdata,
  input wire logic [31:0] fsc_rdata,
  input wire fbrf_pkg::fbrf_rd_req_type rd_req,
  input wire logic rd_valid,
  input wire logic rd_err,
  input wire logic [fbrf_pkg::FBRF_PORT_W-1:0] rd_data,
  input wire logic [fbrf_pkg::FBRF_MTX_W-1:0] mtx_data,
  input wire fbrf_pkg::fbrf_wr_req_type wr_req,
  input wire logic wr_done,
  input wire logic wr_err
);
  timeunit 1ns;
  timeprecision 1ns;
  import fbrf_pkg::*;
  logic rd_ok;
  logic wr_ok;
  // legal views; the matrix is read-only
  assign rd_ok = $onehot(rd_req.view);
  assign wr_ok = $onehot(wr_req.view) && wr_req.view != VW_MATRIX;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  ////////////////////////////////////////////////////////////////////////////
  chk_rd_answer: assert property (rd_req.valid && rd_ok |=>
    rd_valid && !rd_err) else $error("read not answered");
  chk_rd_refuse: assert property (rd_req.valid && !rd_ok |=>
    rd_err && !rd_valid && $stable(rd_data)) else $error("bad read taken");
  chk_rd_quiet: assert property (!rd_req.valid |=>
    !rd_valid && !rd_err) else $error("read answer without request");
  chk_wr_answer: assert property (wr_req.valid && wr_ok |=>
    wr_done && !wr_err) else $error("write not answered");
  chk_wr_refuse: assert property (wr_req.valid && !wr_ok |=>
    wr_err && !wr_done) else $error("bad write taken");
  chk_fsc_mask: assert property (fsc_we |=>
    fsc_rdata == ($past(fsc_wdata) & FSC_WMASK)) else $error("mode word");
  chk_fsc_hold: assert property (!fsc_we |=>
    $stable(fsc_rdata)) else $error("mode word moved");
  chk_mtx_hold: assert property (!(rd_req.valid &&
    rd_req.view == VW_MATRIX) |=> $stable(mtx_data)) else $error("mtx");
  chk_single_pad: assert property (rd_req.valid &&
    rd_req.view == VW_SINGLE && !rd_req.is_move && !fsc_we &&
    !fsc_rdata[FSC_DBL_POS] |=> rd_data[95:0] == '0) else $error("pad");
  // main scenarios
  cover property (rd_req.valid && rd_req.view == VW_MATRIX);
  cover property (fsc_we && rd_req.valid);
  cover property (wr_req.valid && !wr_ok);
endmodule // fbrf_regfile_chk
bind fbrf_regfile fbrf_regfile_chk fbrf_regfile_chk_inst (.clk(clk),
  .rstn(rstn), .fsc_we(fsc_we), .fsc_wdata(fsc_wdata),
  .fsc_rdata(fsc_rdata), .rd_req(rd_req), .rd_valid(rd_valid),
  .rd_err(rd_err), .rd_data(rd_data), .mtx_data(mtx_data),
  .wr_req(wr_req), .wr_done(wr_done), .wr_err(wr_err));
`default_nettype wire

// *** verif/fbrf_fpu_model.sv ***
`default_nettype none
module fbrf_fpu_model (
  input wire logic clk,
  output logic fsc_we,
  output logic [31:0] fsc_wdata,
  output fbrf_pkg::fbrf_rd_req_type rd_req,
  output fbrf_pkg::fbrf_wr_req_type wr_req
);
  timeunit 1ns;
  timeprecision 1ns;
  import fbrf_pkg::*;
  // idle at time zero
  initial begin
    fsc_we = 0;
    fsc_wdata = '0;
    rd_req = '0;
    wr_req = '0;
  end
  // one request for one edge; qualifiers drop and payloads are scrambled afterwards so a
  // stale value can never pass for a held one
  task automatic op(input logic fwe, input logic [31:0] fwd,
    input fbrf_rd_req_type r, input fbrf_wr_req_type w);
    @(posedge clk);
    fsc_we <= fwe;
    fsc_wdata <= fwd;
    rd_req <= r;
    wr_req <= w;
    @(posedge clk);
    fsc_we <= 0;
    fsc_wdata <= ~fwd;
    rd_req <= {1'b0, ~r[10:0]};
    wr_req <= {1'b0, ~w[138:0]};
    #1;
  endtask
endmodule // fbrf_fpu_model
`default_nettype wire

// *** verif/fbrf_regfile_tb.sv ***
`default_nettype none
module fbrf_regfile_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import fbrf_pkg::*;
  logic clk, rstn, fsc_we, rd_valid, rd_err, wr_done, wr_err, sw, pb, db;
  logic [31:0] fsc_wdata, fsc_rdata;
  fbrf_rd_req_type rd_req;
  fbrf_wr_req_type wr_req;
  logic [FBRF_PORT_W-1:0] rd_data, lr;
  logic [FBRF_MTX_W-1:0] mtx_data;
  logic [31:0] mem [32];
  int n_fail, check_count;

  fbrf_regfile fbrf_regfile_inst (.clk(clk), .rstn(rstn), .fsc_we(fsc_we),
    .fsc_wdata(fsc_wdata), .fsc_rdata(fsc_rdata), .rd_req(rd_req),
    .rd_valid(rd_valid), .rd_err(rd_err), .rd_data(rd_data),
    .mtx_data(mtx_data), .wr_req(wr_req), .wr_done(wr_done),
    .wr_err(wr_err));
  fbrf_fpu_model fbrf_fpu_model_inst (.clk(clk), .fsc_we(fsc_we),
    .fsc_wdata(fsc_wdata), .rd_req(rd_req), .wr_req(wr_req));

  // 20 MHz clock
  initial begin
    clk = 0;
    forever #25 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////////
  // counts line, then the verdict; the only exit of the run
  task automatic complete_run;
    $display("checks %0d failures %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // one compare for every result; unknown bits count as wrong
  task automatic chk(input logic [511:0] got, input logic [511:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %0h exp %0h", $time, got, exp);
    end
  endtask
  // one access, judged against shadow words; mode bits written in the
  // same cycle already steer the mapping
  task automatic acc(input logic w, input fbrf_view_type v,
    input logic [3:0] i, input logic mv, input logic [127:0] d,
    input logic fwe = 0, input logic [31:0] fwd = 0);
    int b, c;
    logic [127:0] e;
    logic [511:0] m;
    if (fwe) {sw, pb, db} = fwd[21:19];
    b = sw * 16;
    c = 1;
    case (v)
      VW_SINGLE: c = (mv ? pb : db) ? 2 : 1;
      VW_DOUBLE: c = 2;
      VW_VECTOR: c = 4;
      VW_EXT_SINGLE: c = (mv && pb) ? 2 : 1;
      VW_EXT_DOUBLE: c = 2;
      default: c = 0;
    endcase
    if (v == VW_EXT_SINGLE || v == VW_EXT_DOUBLE) b = 16 - b;
    b += i & (c == 4 ? 12 : c == 2 ? 14 : 15);
    e = '0;
    for (int k = 0; k < c; k++) e[127-32*k -: 32] = mem[b+k];
    for (int k = 0; k < 16; k++) m[511-32*k -: 32] = mem[16-sw*16+k];
    fbrf_fpu_model_inst.op(fwe, fwd, '{~w, mv, v, i}, '{w, mv, v, i, d});
    if (w) begin
      chk(wr_done, c > 0);
      chk(wr_err, c == 0);
      for (int k = 0; k < c; k++) mem[b+k] = d[127-32*k -: 32];
    end else begin
      if (c > 0) lr = e;
      chk(rd_valid, c > 0 || v == VW_MATRIX);
      chk(rd_err, c == 0 && v != VW_MATRIX);
      chk(rd_data, lr);
      if (v == VW_MATRIX) chk(mtx_data, m);
    end
    chk(fsc_rdata, 32'({sw, pb, db}) << 19);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // reset pulse; storage, mode word and outputs all clear
  task automatic t_reset;
    @(posedge clk);
    rstn <= 0;
    repeat (3) @(posedge clk);
    rstn <= 1;
    {sw, pb, db} = 3'h0;
    lr = '0;
    foreach (mem[k]) mem[k] = '0;
    #1;
    chk({fsc_rdata, rd_data, rd_valid, wr_done}, '0);
    chk(mtx_data, '0);
  endtask
  // distinct word in every entry of both banks
  task automatic t_fill;
    for (int i = 0; i < 16; i++) begin
      acc(1, VW_SINGLE, i, 0, {32'h1000_0000 + i, 96'h0});
      acc(1, VW_EXT_SINGLE, i, 0, {32'h2000_0000 + i, 96'h0});
    end
  endtask
  // every view at every index, both bank mappings
  task automatic t_views;
    for (int s = 0; s < 2; s++) begin
      acc(0, VW_SINGLE, 1, 0, 0, 1, 32'(s) << 21);
      for (int j = 0; j < 5; j++)
        for (int i = 0; i < 16; i++)
          acc(0, fbrf_view_type'(6'(1 << j)), i, 0, 0);
      acc(0, VW_MATRIX, 0, 0, 0);
    end
  endtask
  // wide writes land on consecutive words
  task automatic t_wide;
    acc(1, VW_VECTOR, 9, 0, {32'h3000_0001, 32'h3000_0002,
      32'h3000_0003, 32'h3000_0004});
    acc(1, VW_EXT_DOUBLE, 7, 0,
      {32'h3100_0001, 32'h3100_0002, 64'h0});
    acc(0, VW_VECTOR, 8, 0, 0);
    acc(0, VW_EXT_DOUBLE, 6, 0, 0);
    acc(0, VW_MATRIX, 0, 0, 0);
  endtask
  // transfer-pair and double modes, then a masked mode write
  task automatic t_modes;
    acc(0, VW_SINGLE, 5, 1, 0, 1, 32'h0010_0000);
    acc(1, VW_EXT_SINGLE, 3, 1,
      {32'h4000_0001, 32'h4000_0002, 64'h0});
    acc(0, VW_EXT_SINGLE, 3, 0, 0, 1, 32'h0008_0000);
    acc(0, VW_SINGLE, 7, 0, 0);
    acc(0, VW_SINGLE, 7, 1, 0, 1, 32'hFFC7_FFFF);
  endtask
  // refused accesses leave storage and read data alone
  task automatic t_refuse;
    acc(1, VW_MATRIX, 0, 0, '1);
    acc(1, fbrf_view_type'(6'h00), 2, 0, '1);
    acc(0, fbrf_view_type'(6'h03), 2, 0, 0);
    acc(0, VW_MATRIX, 0, 0, 0);
  endtask
  // hang guard
  initial begin
    #2000000;
    n_fail++;
    complete_run();
  end
  initial begin
    rstn = 0;
    t_reset();
    t_fill();
    t_views();
    t_wide();
    t_modes();
    t_refuse();
    t_reset();
    acc(0, VW_DOUBLE, 0, 0, 0);
    complete_run();
  end
endmodule // fbrf_regfile_tb
`default_nettype wire
